// ===== pkg/mcsfr_pkg.sv
package mcsfr_pkg;

  // ==========================================================================
  // Register indices; the byte address on the bus is four times the index.
  // ==========================================================================
  localparam logic [7:0] IDX_PORT_A_LATCH = 8'h80;
  localparam logic [7:0] IDX_STACK_TOP_POINTER = 8'h81;
  localparam logic [7:0] IDX_PRIMARY_POINTER_LOW = 8'h82;
  localparam logic [7:0] IDX_PRIMARY_POINTER_HIGH = 8'h83;
  localparam logic [7:0] IDX_SECONDARY_POINTER_LOW = 8'h84;
  localparam logic [7:0] IDX_SECONDARY_POINTER_HIGH = 8'h85;
  localparam logic [7:0] IDX_ACCESS_STRETCH_CONTROL = 8'h8E;
  localparam logic [7:0] IDX_PORT_B_LATCH = 8'h90;
  localparam logic [7:0] IDX_PORT_B_DIRECTION = 8'h91;
  localparam logic [7:0] IDX_PORT_C_LATCH = 8'hA0;
  localparam logic [7:0] IDX_PORT_C_DIRECTION = 8'hA1;
  localparam logic [7:0] IDX_PORT_A_DIRECTION = 8'hA2;
  localparam logic [7:0] IDX_PROGRAM_COUNTER_LOW = 8'hF8;
  localparam logic [7:0] IDX_PROGRAM_COUNTER_HIGH = 8'hF9;

  // Bus geometry: index bits sit above the two byte-lane bits.
  localparam int ADDR_W = 10;
  localparam int IDX_LSB = 2;

  // ==========================================================================
  // Reset values and field layout.
  // ==========================================================================
  localparam logic [7:0] RST_STACK_TOP_POINTER = 8'h07;
  localparam logic [7:0] RST_PORT_LATCH = 8'hFF;
  localparam logic [7:0] RST_DIRECTION = 8'h00;
  localparam logic [7:0] RST_POINTER_BYTE = 8'h00;
  localparam logic [15:0] RST_PROGRAM_COUNTER = 16'h0000;
  localparam logic [2:0] RST_STRETCH = 3'h1;
  localparam int STRETCH_LSB = 0;
  localparam int STRETCH_W = 3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================================
  // Carriers between the core and the external data move engine.
  // ==========================================================================
  typedef struct packed {
    logic write;
    logic [15:0] addr;
    logic [7:0] wdata;
  } mcsfr_move_req_s;

  typedef struct packed {
    logic addr_valid;
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } mcsfr_mem_bus_s;

  typedef enum logic [1:0] {
    MOVE_IDLE = 2'b01,
    MOVE_BUSY = 2'b10
  } mcsfr_move_state_e;

endpackage : mcsfr_pkg

// ===== src/mcsfr_core_regs.sv
`timescale 1ns/1ns

// What this block does
// [R01] Stack pointer is an 8-bit register that resets to 0x07.
// [R02] Push and call increment the stack pointer first, so stacking starts at 0x08.
// [R03] Two 16-bit data pointers, each written as low and high byte registers.
// [R04] Program counter is 16 bits and resets to 0x0000.
// [R05] Program counter advances with every opcode fetch and program memory operand read.
// [R06] An output-enabled pin follows its latch bit: 1 drives high, 0 drives low.
// [R07] Direction bit 1 makes the pin an output, 0 makes it an input.
// [R08] Three bidirectional ports, each with latch, output driver and input buffer.
// [R09] Reading a port register returns real pin levels, outputs included.
// [R10] Software may count edges of output pins driven by other logic.
// [R11] A 3-bit stretch field selects stretch 0 to 7 for external data moves.
// [R12] External reads hold address and read strobe for stretch plus one cycles.
// [R13] External writes hold address stretch plus two; write strobe max(1, stretch).
// [R14] Stretch field resets to 001; software should leave it there.
// [R15] The default stretch keeps shared data memory accesses by all masters correct.
// [R16] Pin levels pass a two-stage synchronizer before any read.
// [R17] Register writes take effect at the clock edge that completes the write.
module mcsfr_core_regs #(
  parameter int PORT_W = 8
) (
  input wire logic clk_i,
  input wire logic srst_i,
  // AXI4-Lite register slave.
  input wire logic [mcsfr_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [mcsfr_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Core instruction logic.
  input wire logic stack_push_i,
  input wire logic stack_pop_i,
  input wire logic opcode_fetch_i,
  input wire logic operand_fetch_i,
  input wire logic pc_load_i,
  input wire logic [15:0] pc_load_value_i,
  output logic [7:0] stack_top_pointer_o,
  output logic [15:0] primary_pointer_o,
  output logic [15:0] secondary_pointer_o,
  output logic [15:0] program_counter_o,
  // External data move requests and the shared data memory bus.
  input wire logic move_valid_i,
  input wire mcsfr_pkg::mcsfr_move_req_s move_req_i,
  output logic move_ready_o,
  output logic move_done_o,
  output logic [7:0] move_rdata_o,
  output mcsfr_pkg::mcsfr_mem_bus_s mem_bus_o,
  input wire logic [7:0] mem_rdata_i,
  // Digital I/O pins of ports a, b and c, a in the low byte.
  input wire logic [3*PORT_W-1:0] digital_io_i,
  output logic [3*PORT_W-1:0] digital_io_o,
  output logic [3*PORT_W-1:0] digital_io_oe_o
);

  // ==========================================================================
  // Strobe timing of one external data move.
  // ==========================================================================
  // Phase k of a move, counted from 0; returns the memory bus strobes.
  function automatic logic [2:0] move_strobes(input logic [3:0] k, input logic is_write,
                                              input logic [2:0] stretch);
    logic [3:0] addr_len;
    logic [3:0] wr_len;
    logic [2:0] s;
    addr_len = is_write ? ({1'b0, stretch} + 4'h2) : ({1'b0, stretch} + 4'h1);
    wr_len = (stretch < 3'h2) ? 4'h1 : {1'b0, stretch};
    s[2] = (k < addr_len);
    s[1] = !is_write && (k < addr_len);
    s[0] = is_write && (k >= 4'h1) && (k <= wr_len);
    return s;
  endfunction : move_strobes

  // ==========================================================================
  // Register state.
  // ==========================================================================
  logic [7:0] stack_top_pointer;
  logic [7:0] primary_pointer_low;
  logic [7:0] primary_pointer_high;
  logic [7:0] secondary_pointer_low;
  logic [7:0] secondary_pointer_high;
  logic [7:0] access_stretch_control;
  logic [15:0] program_counter;
  logic [3*PORT_W-1:0] port_latch;
  logic [3*PORT_W-1:0] port_direction;
  logic [3*PORT_W-1:0] pin_meta;
  logic [3*PORT_W-1:0] pin_sync;

  // ==========================================================================
  // AXI4-Lite write path.
  // ==========================================================================
  logic aw_held;
  logic w_held;
  logic [mcsfr_pkg::ADDR_W-1:0] aw_addr;
  logic [7:0] w_byte;
  logic w_lane0;

  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire wr_fire = aw_held && w_held && !s_axi_bvalid;
  wire [7:0] wr_idx = aw_addr[mcsfr_pkg::ADDR_W-1:mcsfr_pkg::IDX_LSB];
  wire wr_en = wr_fire && w_lane0;

  // Per-register write strobes; a write without byte lane 0 changes nothing.
  wire wr_stack = wr_en && (wr_idx == mcsfr_pkg::IDX_STACK_TOP_POINTER);
  wire wr_prim_lo = wr_en && (wr_idx == mcsfr_pkg::IDX_PRIMARY_POINTER_LOW);
  wire wr_prim_hi = wr_en && (wr_idx == mcsfr_pkg::IDX_PRIMARY_POINTER_HIGH);
  wire wr_sec_lo = wr_en && (wr_idx == mcsfr_pkg::IDX_SECONDARY_POINTER_LOW);
  wire wr_sec_hi = wr_en && (wr_idx == mcsfr_pkg::IDX_SECONDARY_POINTER_HIGH);
  wire wr_stretch = wr_en && (wr_idx == mcsfr_pkg::IDX_ACCESS_STRETCH_CONTROL);
  wire wr_pc_lo = wr_en && (wr_idx == mcsfr_pkg::IDX_PROGRAM_COUNTER_LOW);
  wire wr_pc_hi = wr_en && (wr_idx == mcsfr_pkg::IDX_PROGRAM_COUNTER_HIGH);
  wire [2:0] wr_latch = {wr_en && (wr_idx == mcsfr_pkg::IDX_PORT_C_LATCH),
                         wr_en && (wr_idx == mcsfr_pkg::IDX_PORT_B_LATCH),
                         wr_en && (wr_idx == mcsfr_pkg::IDX_PORT_A_LATCH)};
  wire [2:0] wr_dir = {wr_en && (wr_idx == mcsfr_pkg::IDX_PORT_C_DIRECTION),
                       wr_en && (wr_idx == mcsfr_pkg::IDX_PORT_B_DIRECTION),
                       wr_en && (wr_idx == mcsfr_pkg::IDX_PORT_A_DIRECTION)};
  wire wr_mapped = (|wr_latch) || (|wr_dir) || wr_stack || wr_prim_lo || wr_prim_hi || wr_sec_lo || wr_sec_hi ||
                   wr_stretch || (wr_idx == mcsfr_pkg::IDX_PROGRAM_COUNTER_LOW) ||
                   (wr_idx == mcsfr_pkg::IDX_PROGRAM_COUNTER_HIGH);
  wire wr_known = (wr_idx == mcsfr_pkg::IDX_PORT_A_LATCH) || (wr_idx == mcsfr_pkg::IDX_PORT_B_LATCH) ||
                  (wr_idx == mcsfr_pkg::IDX_PORT_C_LATCH) || (wr_idx == mcsfr_pkg::IDX_PORT_A_DIRECTION) ||
                  (wr_idx == mcsfr_pkg::IDX_PORT_B_DIRECTION) || (wr_idx == mcsfr_pkg::IDX_PORT_C_DIRECTION) ||
                  (wr_idx == mcsfr_pkg::IDX_STACK_TOP_POINTER) || (wr_idx == mcsfr_pkg::IDX_PRIMARY_POINTER_LOW) ||
                  (wr_idx == mcsfr_pkg::IDX_PRIMARY_POINTER_HIGH) ||
                  (wr_idx == mcsfr_pkg::IDX_SECONDARY_POINTER_LOW) ||
                  (wr_idx == mcsfr_pkg::IDX_SECONDARY_POINTER_HIGH) ||
                  (wr_idx == mcsfr_pkg::IDX_ACCESS_STRETCH_CONTROL) || wr_mapped;

  // Address and data are caught independently, so either may arrive first.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_byte <= 8'h00;
      w_lane0 <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= mcsfr_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held && !aw_take && !s_axi_bvalid;
      s_axi_wready <= !w_held && !w_take && !s_axi_bvalid;
      if (aw_take) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (w_take) begin
        w_held <= 1'b1;
        w_byte <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? mcsfr_pkg::RESP_OKAY : mcsfr_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // AXI4-Lite read path.
  // ==========================================================================
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire [7:0] rd_idx = s_axi_araddr[mcsfr_pkg::ADDR_W-1:mcsfr_pkg::IDX_LSB];
  wire [7:0] pin_a = pin_sync[PORT_W-1:0];
  wire [7:0] pin_b = pin_sync[2*PORT_W-1:PORT_W];
  wire [7:0] pin_c = pin_sync[3*PORT_W-1:2*PORT_W];
  logic [8:0] rd_sel;

  // Bit 8 flags a mapped index. Port reads show synchronised pin levels. [R09]
  always_comb begin
    unique case (rd_idx)
      mcsfr_pkg::IDX_PORT_A_LATCH: rd_sel = {1'b1, pin_a};
      mcsfr_pkg::IDX_PORT_B_LATCH: rd_sel = {1'b1, pin_b};
      mcsfr_pkg::IDX_PORT_C_LATCH: rd_sel = {1'b1, pin_c};
      mcsfr_pkg::IDX_PORT_A_DIRECTION: rd_sel = {1'b1, port_direction[PORT_W-1:0]};
      mcsfr_pkg::IDX_PORT_B_DIRECTION: rd_sel = {1'b1, port_direction[2*PORT_W-1:PORT_W]};
      mcsfr_pkg::IDX_PORT_C_DIRECTION: rd_sel = {1'b1, port_direction[3*PORT_W-1:2*PORT_W]};
      mcsfr_pkg::IDX_STACK_TOP_POINTER: rd_sel = {1'b1, stack_top_pointer};
      mcsfr_pkg::IDX_PRIMARY_POINTER_LOW: rd_sel = {1'b1, primary_pointer_low};
      mcsfr_pkg::IDX_PRIMARY_POINTER_HIGH: rd_sel = {1'b1, primary_pointer_high};
      mcsfr_pkg::IDX_SECONDARY_POINTER_LOW: rd_sel = {1'b1, secondary_pointer_low};
      mcsfr_pkg::IDX_SECONDARY_POINTER_HIGH: rd_sel = {1'b1, secondary_pointer_high};
      mcsfr_pkg::IDX_ACCESS_STRETCH_CONTROL: rd_sel = {1'b1, access_stretch_control};
      mcsfr_pkg::IDX_PROGRAM_COUNTER_LOW: rd_sel = {1'b1, program_counter[7:0]};
      mcsfr_pkg::IDX_PROGRAM_COUNTER_HIGH: rd_sel = {1'b1, program_counter[15:8]};
      default: rd_sel = 9'h000;
    endcase
  end

  // One read in flight; arready drops while the answer waits for rready.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= mcsfr_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !ar_take;
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h00_0000, rd_sel[7:0]};
        s_axi_rresp <= rd_sel[8] ? mcsfr_pkg::RESP_OKAY : mcsfr_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Core pointers and program counter.
  // ==========================================================================
  // Push pre-increments, so from reset the first stacked byte sits at 0x08. [R02]
  wire [7:0] next_stack_top_pointer = stack_push_i ? (stack_top_pointer + 8'h01) :
                                      stack_pop_i ? (stack_top_pointer - 8'h01) : stack_top_pointer;
  // One step per fetched opcode byte and per operand byte from program memory. [R05]
  wire [15:0] pc_step = {15'h0000, opcode_fetch_i} + {15'h0000, operand_fetch_i};
  wire [15:0] next_program_counter = pc_load_i ? pc_load_value_i : (program_counter + pc_step);

  // A bus write in the same cycle as a core update wins; software owns the value it writes.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      stack_top_pointer <= mcsfr_pkg::RST_STACK_TOP_POINTER; // [R01]
      program_counter <= mcsfr_pkg::RST_PROGRAM_COUNTER; // [R04]
      primary_pointer_low <= mcsfr_pkg::RST_POINTER_BYTE;
      primary_pointer_high <= mcsfr_pkg::RST_POINTER_BYTE;
      secondary_pointer_low <= mcsfr_pkg::RST_POINTER_BYTE;
      secondary_pointer_high <= mcsfr_pkg::RST_POINTER_BYTE;
    end else begin
      stack_top_pointer <= wr_stack ? w_byte : next_stack_top_pointer; // [R17]
      if (wr_pc_lo) begin
        program_counter <= {next_program_counter[15:8], w_byte};
      end else if (wr_pc_hi) begin
        program_counter <= {w_byte, next_program_counter[7:0]};
      end else begin
        program_counter <= next_program_counter; // [R05]
      end
      if (wr_prim_lo) primary_pointer_low <= w_byte; // [R03]
      if (wr_prim_hi) primary_pointer_high <= w_byte; // [R03]
      if (wr_sec_lo) secondary_pointer_low <= w_byte; // [R03]
      if (wr_sec_hi) secondary_pointer_high <= w_byte; // [R03]
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      stack_top_pointer_o <= mcsfr_pkg::RST_STACK_TOP_POINTER;
      program_counter_o <= mcsfr_pkg::RST_PROGRAM_COUNTER;
      primary_pointer_o <= {mcsfr_pkg::RST_POINTER_BYTE, mcsfr_pkg::RST_POINTER_BYTE};
      secondary_pointer_o <= {mcsfr_pkg::RST_POINTER_BYTE, mcsfr_pkg::RST_POINTER_BYTE};
    end else begin
      stack_top_pointer_o <= stack_top_pointer;
      program_counter_o <= program_counter;
      primary_pointer_o <= {primary_pointer_high, primary_pointer_low};
      secondary_pointer_o <= {secondary_pointer_high, secondary_pointer_low};
    end
  end

  // ==========================================================================
  // Digital I/O ports.
  // ==========================================================================
  // Each port has a latch, a direction byte and a synchronised input path. [R08]
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      port_latch <= {3{mcsfr_pkg::RST_PORT_LATCH}};
      port_direction <= {3{mcsfr_pkg::RST_DIRECTION}};
    end else begin
      for (int p = 0; p < 3; p++) begin
        if (wr_latch[p]) port_latch[p*PORT_W +: PORT_W] <= w_byte[PORT_W-1:0]; // [R17]
        if (wr_dir[p]) port_direction[p*PORT_W +: PORT_W] <= w_byte[PORT_W-1:0]; // [R07]
      end
    end
  end

  // Pins change with no regard for clk_i; only the second stage is read. [R16]
  always_ff @(posedge clk_i) begin
    pin_meta <= digital_io_i;
    pin_sync <= pin_meta;
  end

  // Latch values drive the pins whose direction bit is 1. [R06] [R07]
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      digital_io_o <= {3{mcsfr_pkg::RST_PORT_LATCH}};
      digital_io_oe_o <= {3{mcsfr_pkg::RST_DIRECTION}};
    end else begin
      digital_io_o <= port_latch; // [R06]
      digital_io_oe_o <= port_direction; // [R07]
    end
  end

  // ==========================================================================
  // Stretch control and external data move engine.
  // ==========================================================================
  // Only the stretch field is stored; other bits read as zero. [R14]
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      access_stretch_control <= {5'h00, mcsfr_pkg::RST_STRETCH}; // [R14]
    end else if (wr_stretch) begin
      access_stretch_control <= {5'h00, w_byte[mcsfr_pkg::STRETCH_LSB +: mcsfr_pkg::STRETCH_W]}; // [R11]
    end
  end

  mcsfr_pkg::mcsfr_move_state_e move_state;
  logic [3:0] move_phase;
  logic move_write;
  logic [2:0] move_stretch;

  // The stretch is frozen at the start of a move, so a write mid-move cannot tear it. [R15]
  wire [2:0] cur_stretch = access_stretch_control[mcsfr_pkg::STRETCH_LSB +: mcsfr_pkg::STRETCH_W];
  wire move_start = (move_state == mcsfr_pkg::MOVE_IDLE) && move_valid_i;
  wire [3:0] next_phase = move_phase + 4'h1;
  wire [2:0] start_strobes = move_strobes(4'h0, move_req_i.write, cur_stretch); // [R11]
  wire [2:0] step_strobes = move_strobes(next_phase, move_write, move_stretch); // [R12] [R13]
  wire move_last = !step_strobes[2];

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      move_state <= mcsfr_pkg::MOVE_IDLE;
      move_phase <= 4'h0;
      move_write <= 1'b0;
      move_stretch <= mcsfr_pkg::RST_STRETCH;
      move_ready_o <= 1'b0;
      move_done_o <= 1'b0;
      move_rdata_o <= 8'h00;
      mem_bus_o <= '0;
    end else begin
      move_done_o <= 1'b0;
      unique case (move_state)
        mcsfr_pkg::MOVE_IDLE: begin
          move_ready_o <= !move_valid_i;
          if (move_start) begin
            move_state <= mcsfr_pkg::MOVE_BUSY;
            move_phase <= 4'h0;
            move_write <= move_req_i.write;
            move_stretch <= cur_stretch;
            mem_bus_o <= {start_strobes, move_req_i.addr, move_req_i.wdata};
          end
        end
        mcsfr_pkg::MOVE_BUSY: begin
          move_phase <= next_phase;
          mem_bus_o.addr_valid <= step_strobes[2]; // [R12] [R13]
          mem_bus_o.rd <= step_strobes[1]; // [R12]
          mem_bus_o.wr <= step_strobes[0]; // [R13]
          if (move_last) begin
            // Read data is taken in the final cycle of the read strobe.
            if (!move_write) move_rdata_o <= mem_rdata_i;
            move_state <= mcsfr_pkg::MOVE_IDLE;
            move_done_o <= 1'b1;
            move_ready_o <= 1'b1;
          end
        end
      endcase
    end
  end

endmodule : mcsfr_core_regs

// ===== verification/mcsfr_core_regs_bench.sv
`timescale 1ns/1ns

// ====================
// Register, stack, port and move tests.
// ====================
module mcsfr_core_regs_bench;
  logic clk_i = 1'h0;
  logic srst_i = 1'h1;
  logic awv = 1'h0, wv = 1'h0, bre = 1'h0, arv = 1'h0, rre = 1'h0, push = 1'h0, opf = 1'h0, dpf = 1'h0, mvv = 1'h0;
  logic pop = 1'h0;
  logic awr, wr, bv, arr, rv, mrdy, mdone;
  logic [9:0] awa = 10'h0, ara = 10'h0;
  logic [31:0] wd = 32'h0, rd;
  logic [3:0] ws = 4'hF;
  logic [1:0] br, rr;
  logic [7:0] spo, mrdat, mdin;
  logic [15:0] ppo, p2o, pco;
  logic [23:0] pin_i, pin_o, pin_oe;
  mcsfr_pkg::mcsfr_move_req_s mreq = '0;
  mcsfr_pkg::mcsfr_mem_bus_s mbus;
  int err_count = 0, n_compared = 0, cyc = 0;

  mcsfr_core_regs dut (.clk_i(clk_i), .srst_i(srst_i), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre),
    .stack_push_i(push), .stack_pop_i(pop), .opcode_fetch_i(opf), .operand_fetch_i(dpf), .pc_load_i(1'h0),
    .pc_load_value_i(16'h0), .stack_top_pointer_o(spo), .primary_pointer_o(ppo), .secondary_pointer_o(p2o),
    .program_counter_o(pco), .move_valid_i(mvv), .move_req_i(mreq), .move_ready_o(mrdy), .move_done_o(mdone),
    .move_rdata_o(mrdat), .mem_bus_o(mbus), .mem_rdata_i(mdin), .digital_io_i(pin_i), .digital_io_o(pin_o),
    .digital_io_oe_o(pin_oe));
  mcsfr_far_side u_far (.clk_i(clk_i), .mem_bus_i(mbus), .mem_rdata_o(mdin), .pin_drive_i(pin_o),
    .pin_oe_i(pin_oe), .pin_ext_i(24'hA0A0A0), .pin_level_o(pin_i));

  task automatic give_verdict();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  // Write and read hold each channel until its ready edge, as the bus demands.
  task automatic axi_wr(input logic [7:0] ix, input logic [7:0] d);
    logic ta, tw;
    ta = 1'h0;
    tw = 1'h0;
    awa <= {ix, 2'h0};
    wd <= {24'h0, d};
    awv <= 1'h1;
    wv <= 1'h1;
    bre <= 1'h1;
    do begin
      @(posedge clk_i);
      ta = ta | awr;
      tw = tw | wr;
      awv <= ~ta;
      wv <= ~tw;
    end while (!(ta && tw));
    while (!bv) @(posedge clk_i);
    check(br, mcsfr_pkg::RESP_OKAY);
    bre <= 1'h0;
    @(posedge clk_i);
  endtask : axi_wr

  task automatic rd_is(input logic [7:0] ix, input logic [1:0] er, input logic [7:0] ed);
    ara <= {ix, 2'h0};
    arv <= 1'h1;
    rre <= 1'h1;
    do @(posedge clk_i); while (!arr);
    arv <= 1'h0;
    while (!rv) @(posedge clk_i);
    check({rr, rd}, {er, 24'h0, ed});
    rre <= 1'h0;
    @(posedge clk_i);
  endtask : rd_is

  // One move at address s; strobe widths are counted until done.
  task automatic move(input logic w, input logic [2:0] s);
    int na, nr, nw;
    na = 0;
    nr = 0;
    nw = 0;
    mreq <= {w, 13'h0, s, 8'h3C};
    while (!mrdy) @(posedge clk_i);
    mvv <= 1'h1;
    @(posedge clk_i);
    mvv <= 1'h0;
    do begin
      @(posedge clk_i);
      na += mbus.addr_valid;
      nr += mbus.rd;
      nw += mbus.wr;
    end while (!mdone);
    if (w) begin
      check(na, s + 2);
      check(nw, (s < 2) ? 1 : s);
    end else begin
      check(nr * 16 + na, (s + 1) * 17);
      check(mrdat, {5'h0, s} ^ 8'hA5);
    end
  endtask : move

  // Clock, and a ceiling far above the few hundred cycles the tests need.
  always #25 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      give_verdict();
    end
  end

  // Main sequence.
  initial begin
    repeat (6) @(posedge clk_i);
    srst_i <= 1'h0;
    repeat (2) @(posedge clk_i);
    rd_is(8'h81, 2'h0, 8'h07);
    rd_is(8'h8E, 2'h0, 8'h01);
    rd_is(8'hF8, 2'h0, 8'h00);
    rd_is(8'h86, mcsfr_pkg::RESP_SLVERR, 8'h00);
    $display("reset test done");
    axi_wr(8'h82, 8'h34);
    axi_wr(8'h83, 8'h12);
    axi_wr(8'h84, 8'h78);
    axi_wr(8'h85, 8'h56);
    push <= 1'h1;
    opf <= 1'h1;
    dpf <= 1'h1;
    @(posedge clk_i);
    push <= 1'h0;
    dpf <= 1'h0;
    repeat (3) @(posedge clk_i);
    opf <= 1'h0;
    repeat (3) @(posedge clk_i);
    check(ppo, 16'h1234);
    check(p2o, 16'h5678);
    check(spo, 8'h08);
    check(pco, 16'h0005);
    pop <= 1'h1;
    @(posedge clk_i);
    pop <= 1'h0;
    repeat (3) @(posedge clk_i);
    check(spo, 8'h07);
    rd_is(8'hF8, 2'h0, 8'h05);
    $display("pointer test done");
    axi_wr(8'hA2, 8'hFF);
    axi_wr(8'h80, 8'h3C);
    axi_wr(8'h91, 8'h0F);
    axi_wr(8'h90, 8'h05);
    repeat (3) @(posedge clk_i);
    check(pin_o, 24'hFF053C);
    check(pin_oe, 24'h000FFF);
    rd_is(8'h80, 2'h0, 8'h3C);
    rd_is(8'h90, 2'h0, 8'hA5);
    rd_is(8'hA0, 2'h0, 8'hA0);
    $display("port test done");
    move(1'h0, 3'h1);
    for (int s = 0; s < 8; s++) begin
      axi_wr(8'h8E, {5'h0, s[2:0]});
      move(1'h0, s[2:0]);
      move(1'h1, s[2:0]);
    end
    $display("stretch test done");
    give_verdict();
  end
endmodule : mcsfr_core_regs_bench

// ===== verification/mcsfr_core_regs_properties.sv
`timescale 1ns/1ns

// ====================
// Stack and move strobe checks.
// ====================
module mcsfr_chk (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic stack_push_i,
  input wire logic s_axi_awready,
  input wire logic [7:0] stack_top_pointer_o,
  input wire mcsfr_pkg::mcsfr_mem_bus_s mem_bus_o,
  input wire logic move_done_o
);
  // One clock domain, so one clocking and one reset serve every check.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  // A read strobe must end within eight cycles, its length at the widest stretch of 7.
  sequence rd_start;
    $rose(mem_bus_o.rd);
  endsequence
  sequence rd_gone;
    ##[1:8] !mem_bus_o.rd;
  endsequence

  chk_stack_reset: assert property (
    $fell(srst_i) |-> stack_top_pointer_o == 8'h07) else $error("stack pointer wrong after reset");
  chk_stack_pre_inc: assert property (
    stack_push_i && s_axi_awready && !$past(stack_push_i) |->
    ##2 stack_top_pointer_o == $past(stack_top_pointer_o) + 8'h01) else $error("push did not add one");
  chk_rd_with_addr: assert property (
    mem_bus_o.rd |-> mem_bus_o.addr_valid && !mem_bus_o.wr) else $error("read strobe without address");
  chk_rd_bounded: assert property (
    rd_start |-> rd_gone) else $error("read strobe too long");
  chk_wr_after_addr: assert property (
    $rose(mem_bus_o.wr) |-> $past(mem_bus_o.addr_valid) && mem_bus_o.addr_valid) else $error("write strobe early");
  chk_addr_bounded: assert property (
    $rose(mem_bus_o.addr_valid) |-> ##[1:9] !mem_bus_o.addr_valid) else $error("address phase too long");
  chk_done_at_end: assert property (
    $fell(mem_bus_o.addr_valid) |-> move_done_o) else $error("no done as the move ended");
  chk_done_single: assert property (
    move_done_o |=> !move_done_o) else $error("done longer than one cycle");
endmodule : mcsfr_chk

bind mcsfr_core_regs mcsfr_chk u_chk (.clk_i(clk_i), .srst_i(srst_i), .stack_push_i(stack_push_i),
  .s_axi_awready(s_axi_awready), .stack_top_pointer_o(stack_top_pointer_o), .mem_bus_o(mem_bus_o),
  .move_done_o(move_done_o));

// ===== verification/mcsfr_far_side.sv
`timescale 1ns/1ns

// ====================
// Pins with board levels and the shared data memory.
// ====================
module mcsfr_far_side (
  input wire logic clk_i,
  input wire mcsfr_pkg::mcsfr_mem_bus_s mem_bus_i,
  output logic [7:0] mem_rdata_o,
  input wire logic [23:0] pin_drive_i,
  input wire logic [23:0] pin_oe_i,
  input wire logic [23:0] pin_ext_i,
  output logic [23:0] pin_level_o
);
  logic [7:0] last_q = 8'h00;
  // A driven pin shows its latch bit, an undriven one the board level.
  assign pin_level_o = (pin_oe_i & pin_drive_i) | (~pin_oe_i & pin_ext_i);
  // Data is valid only under the read strobe; elsewhere it toggles so stale data cannot pass.
  assign mem_rdata_o = mem_bus_i.rd ? (mem_bus_i.addr[7:0] ^ 8'hA5) : ~last_q;
  always_ff @(posedge clk_i) begin
    last_q <= mem_rdata_o;
  end
endmodule : mcsfr_far_side
